// ==== tooth_threshold_switch_logic.sv ====
// Running-mode tooth threshold tracking and switched output with register slave
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`include "tooth_cfg.svh"
// Function
// - Output low or high on tooth, selectable
// - Tooth memory count programmable one to twelve
// - Count one uses previous tooth peak
// - Larger count uses peak n teeth earlier
// - Continuous mode takes every previous valley
// - Bounded mode rejects large valley jumps
// - Points are percent of peak-to-peak span
// - Fixed options place points at 30 or 50
// - Custom points 30 to 50 in 1/64 steps
// - Hysteresis about ten percent, 4/64 to 9/64 of span
// - Flag drops beyond operate point minus fifteen
// - Edges independent of target rotation direction
// - Output switches on thresholds with hysteresis
module tooth_threshold_switch_logic (
   // Clock, reset and clock enable
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   // Avalon-MM register slave
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Sampled magnetic signal
   input wire logic [`SAMPLE_W-1:0] sample,
   input wire logic sampleValid,
   // Switched output to the engine controller
   output logic switchOut
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   tooth_if tif();
   logic busAck_r;
   logic busReq;
   logic wrDone;
   logic rdTake;
   logic [31:0] beMask;
   logic [31:0] rdMux;
   logic [31:0] merged;
   logic [31:0] ctrlWord, memWord, pointsWord, boundWord, statusWord;
   logic wrCtrl, wrMemCnt, wrPoints, wrBound, wrStatus;
   logic highPol_r;
   logic boundedMode_r;
   tooth_pkg::pointMode_t pointMode_r;
   logic runEn_r;
   logic [3:0] memCount_r;
   logic [3:0] memCntIn;
   logic [3:0] memCntClamped;
   logic [5:0] opCode_r, relCode_r;
   logic [3:0] hystCode_r;
   tooth_pkg::sample_t valleyBound_r;
   logic dropHit_r;
   logic dropSet, dropClr;
   tooth_pkg::trackState_t state_r, state_nxt;
   logic sampleTick;
   logic aboveOp, belowRel;
   logic goTooth, goValley, leaveHold;
   tooth_pkg::sample_t curMax_r, curMax_nxt;
   tooth_pkg::sample_t curMin_r, curMin_nxt;
   tooth_pkg::sample_t valleyRef_r;
   tooth_pkg::sample_t valleyDiff;
   logic jumpBig;
   logic valleyLoad;
   logic toothNxt;
   logic polNxt;
   logic switchOut_r;

   // ----------------------------------------
   // Bus handshake
   // ----------------------------------------
   // One wait cycle per access; held off while the clock enable is low
   assign busReq = read | write;
   assign waitrequest = busReq & ~(busAck_r & clkEn);
   assign wrDone = write & busAck_r & clkEn;
   assign rdTake = read & ~busAck_r & clkEn;

   // Acknowledge flag toggles on for one cycle per access
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busAck_r <= 1'b0;
      end else if (clkEn) begin
         busAck_r <= busReq & ~busAck_r;
      end
   end

   // Read data captured in the wait cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         readdata <= 32'h0;
      end else if (rdTake) begin
         readdata <= rdMux;
      end
   end

   // ----------------------------------------
   // Register decode and read mux
   // ----------------------------------------
   assign wrCtrl = wrDone & (address == `OFS_CTRL);
   assign wrMemCnt = wrDone & (address == `OFS_MEMCNT);
   assign wrPoints = wrDone & (address == `OFS_POINTS);
   assign wrBound = wrDone & (address == `OFS_BOUND);
   assign wrStatus = wrDone & (address == `OFS_STATUS);

   // Register words as read back
   assign ctrlWord = {27'h0, runEn_r, pointMode_r, boundedMode_r, highPol_r};
   assign memWord = {28'h0, memCount_r};
   assign pointsWord = {12'h0, hystCode_r, 2'h0, relCode_r, 2'h0, opCode_r};
   assign boundWord = {20'h0, valleyBound_r};
   assign statusWord = {29'h0, dropHit_r, state_r == tooth_pkg::ST_TOOTH, switchOut};

   // Unmapped addresses read as zero
   assign rdMux = (address == `OFS_CTRL) ? ctrlWord :
      (address == `OFS_MEMCNT) ? memWord :
      (address == `OFS_POINTS) ? pointsWord :
      (address == `OFS_BOUND) ? boundWord :
      (address == `OFS_STATUS) ? statusWord :
      (address == `OFS_PEAK) ? {20'h0, tif.peakOut} :
      (address == `OFS_VALLEY) ? {20'h0, valleyRef_r} :
      (address == `OFS_OPTH) ? {20'h0, tif.opRise} :
      (address == `OFS_RELTH) ? {20'h0, tif.relFall} : 32'h0;

   // Byte lanes merge new data into the current word
   assign beMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
      {8{byteenable[1]}}, {8{byteenable[0]}}};
   assign merged = (rdMux & ~beMask) | (writedata & beMask);

   // Tooth count held within one to twelve
   assign memCntIn = merged[3:0];
   assign memCntClamped = (memCntIn == 4'h0) ? 4'h1 :
      (memCntIn > `MEM_MAX) ? `MEM_MAX : memCntIn;

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   // Polarity, valley policy, point mode and run enable
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         highPol_r <= 1'b0;
         boundedMode_r <= 1'b0;
         pointMode_r <= tooth_pkg::PT_THIRTY;
         runEn_r <= 1'b0;
      end else if (wrCtrl) begin
         highPol_r <= merged[`CTRL_POL_BIT];
         boundedMode_r <= merged[`CTRL_BOUND_BIT];
         pointMode_r <= (merged[`CTRL_MODE_LSB+:2] == 2'h3) ? tooth_pkg::PT_CUSTOM :
            tooth_pkg::pointMode_t'(merged[`CTRL_MODE_LSB+:2]);
         runEn_r <= merged[`CTRL_RUN_BIT];
      end
   end

   // Memory count; a new count restarts the store
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         memCount_r <= `RST_MEMCNT;
      end else if (wrMemCnt) begin
         memCount_r <= memCntClamped;
      end
   end

   // Custom operate, release and hysteresis codes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         opCode_r <= `RST_CODE;
         relCode_r <= `RST_CODE;
         hystCode_r <= `RST_HYS;
      end else if (wrPoints) begin
         opCode_r <= merged[`PTS_OP_LSB+:6];
         relCode_r <= merged[`PTS_REL_LSB+:6];
         hystCode_r <= merged[`PTS_HYS_LSB+:4];
      end
   end

   // Largest accepted valley step in bounded mode
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         valleyBound_r <= `RST_BOUND;
      end else if (wrBound) begin
         valleyBound_r <= merged[`SAMPLE_W-1:0];
      end
   end

   // Amplitude drop flag: set wins over a write-one clear
   assign dropClr = wrStatus & writedata[`STAT_DROP_BIT] & byteenable[0];
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dropHit_r <= 1'b0;
      end else if (clkEn) begin
         dropHit_r <= dropSet | (dropHit_r & ~dropClr);
      end
   end

   // ----------------------------------------
   // Sub-blocks
   // ----------------------------------------
   assign tif.memCount = memCount_r;
   assign tif.ptrClear = wrMemCnt;
   assign tif.peakIn = curMax_r;
   assign tif.peakWr = goValley | leaveHold;
   assign tif.peakRef = tif.peakOut;
   assign tif.valleyRef = valleyRef_r;
   assign tif.pointMode = pointMode_r;
   assign tif.opCode = opCode_r;
   assign tif.relCode = relCode_r;
   assign tif.hystCode = hystCode_r;

   // Peak store
   peak_memory #(.MEM_DEPTH(12)) u_mem (
      .ref_clk(ref_clk),
      .rst(rst),
      .clkEn(clkEn),
      .io(tif.mem_side)
   );

   // Threshold arithmetic
   switch_point_calc u_calc (
      .ref_clk(ref_clk),
      .rst(rst),
      .io(tif.calc_side)
   );

   // ----------------------------------------
   // Tooth and valley tracking
   // ----------------------------------------
   // Level comparisons only, so either rotation gives the same edges
   assign sampleTick = clkEn & sampleValid;
   assign aboveOp = sample > tif.opRise;
   assign belowRel = sample < tif.relFall;

   // Switch state on thresholds with hysteresis
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         tooth_pkg::ST_HOLD: begin
            if (runEn_r) state_nxt = tooth_pkg::ST_VALLEY;
         end
         tooth_pkg::ST_VALLEY: begin
            if (!runEn_r) state_nxt = tooth_pkg::ST_HOLD;
            else if (aboveOp) state_nxt = tooth_pkg::ST_TOOTH;
         end
         tooth_pkg::ST_TOOTH: begin
            if (!runEn_r) state_nxt = tooth_pkg::ST_HOLD;
            else if (belowRel) state_nxt = tooth_pkg::ST_VALLEY;
         end
      endcase
   end

   // Transition strobes
   assign goTooth = sampleTick & (state_r == tooth_pkg::ST_VALLEY) &
      (state_nxt == tooth_pkg::ST_TOOTH);
   assign goValley = sampleTick & (state_r == tooth_pkg::ST_TOOTH) &
      (state_nxt == tooth_pkg::ST_VALLEY);
   assign leaveHold = sampleTick & (state_r == tooth_pkg::ST_HOLD) & runEn_r;

   // Peak follows in tooth, valley follows in valley, both while held
   assign curMax_nxt = goTooth ? sample :
      (state_r != tooth_pkg::ST_VALLEY && sample > curMax_r) ? sample : curMax_r;
   assign curMin_nxt = goValley ? sample :
      (state_r != tooth_pkg::ST_TOOTH && sample < curMin_r) ? sample : curMin_r;

   // State and running extremes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= tooth_pkg::ST_HOLD;
         curMax_r <= '0;
         curMin_r <= '1;
      end else if (sampleTick) begin
         state_r <= state_nxt;
         curMax_r <= curMax_nxt;
         curMin_r <= curMin_nxt;
      end
   end

   // Valley step size against the last accepted valley
   assign valleyDiff = curMin_r > valleyRef_r ? curMin_r - valleyRef_r :
      valleyRef_r - curMin_r;
   assign jumpBig = valleyDiff > valleyBound_r;
   assign valleyLoad = leaveHold | (goTooth & (~boundedMode_r | ~jumpBig));

   // Valley reference for the next tooth
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         valleyRef_r <= '0;
      end else if (valleyLoad) begin
         valleyRef_r <= curMin_r;
      end
   end

   // Tooth fell short of the stored peak by more than allowed
   assign dropSet = goValley &
      (({1'b0, curMax_r} + {1'b0, tif.dropAmt}) < {1'b0, tif.peakOut});

   // ----------------------------------------
   // Output stage
   // ----------------------------------------
   assign toothNxt = sampleTick ? (state_nxt == tooth_pkg::ST_TOOTH) :
      (state_r == tooth_pkg::ST_TOOTH);
   assign polNxt = wrCtrl ? merged[`CTRL_POL_BIT] : highPol_r;

   // High-on-tooth passes the state, low-on-tooth inverts it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         switchOut_r <= 1'b1;
      end else if (clkEn) begin
         switchOut_r <= toothNxt ~^ polNxt;
      end
   end
   assign switchOut = switchOut_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_polarity;
      switchOut == ((state_r == tooth_pkg::ST_TOOTH) ~^ highPol_r);
   endproperty
   a_polarity: assert property (p_polarity) else $error("output polarity wrong");

   property p_count;
      memCount_r >= 4'h1 && memCount_r <= `MEM_MAX;
   endproperty
   a_count: assert property (p_count) else $error("memory count out of range");

   property p_tooth_on;
      sampleTick && runEn_r && state_r == tooth_pkg::ST_VALLEY && sample > tif.opRise
         |=> state_r == tooth_pkg::ST_TOOTH && switchOut == highPol_r;
   endproperty
   a_tooth_on: assert property (p_tooth_on) else $error("missed tooth entry");

   property p_valley_on;
      sampleTick && runEn_r && state_r == tooth_pkg::ST_TOOTH && sample < tif.relFall
         |=> state_r == tooth_pkg::ST_VALLEY;
   endproperty
   a_valley_on: assert property (p_valley_on) else $error("missed valley entry");

   property p_cause;
      $past(state_r) == tooth_pkg::ST_VALLEY && state_r == tooth_pkg::ST_TOOTH
         |-> $past(sample) > $past(tif.opRise);
   endproperty
   a_cause: assert property (p_cause) else $error("tooth without crossing");

   property p_valley_cont;
      $past(goTooth) && !$past(boundedMode_r) |-> valleyRef_r == $past(curMin_r);
   endproperty
   a_valley_cont: assert property (p_valley_cont) else $error("valley not taken");

   property p_valley_bound;
      $past(goTooth) && $past(boundedMode_r) && $past(jumpBig)
         |-> valleyRef_r == $past(valleyRef_r);
   endproperty
   a_valley_bound: assert property (p_valley_bound) else $error("jump not filtered");

   property p_drop;
      dropSet && clkEn |=> dropHit_r ##1 (dropHit_r || $past(dropClr));
   endproperty
   a_drop: assert property (p_drop) else $error("drop flag lost");
endmodule // tooth_threshold_switch_logic

// ==== tooth_cfg.svh ====
// Offsets, field positions, reset values and limits of the tooth switch logic
`ifndef TOOTH_CFG_SVH
`define TOOTH_CFG_SVH
`define SAMPLE_W 12
// Register byte offsets
`define OFS_CTRL 6'h00
`define OFS_MEMCNT 6'h04
`define OFS_POINTS 6'h08
`define OFS_BOUND 6'h0c
`define OFS_STATUS 6'h10
`define OFS_PEAK 6'h14
`define OFS_VALLEY 6'h18
`define OFS_OPTH 6'h1c
`define OFS_RELTH 6'h20
// Field positions
`define CTRL_POL_BIT 0
`define CTRL_BOUND_BIT 1
`define CTRL_MODE_LSB 2
`define CTRL_RUN_BIT 4
`define PTS_OP_LSB 0
`define PTS_REL_LSB 8
`define PTS_HYS_LSB 16
`define STAT_DROP_BIT 2
// Reset values
`define RST_MEMCNT 4'h1
`define RST_CODE 6'h13
`define RST_HYS 4'h6
`define RST_BOUND 12'h040
// Point codes in steps of 1/64 of peak-to-peak, and the tooth count limit
`define CODE_THIRTY 6'h13
`define CODE_FIFTY 6'h20
`define HYS_MIN 4'h4
`define HYS_MAX 4'h9
`define DROP_MARGIN 6'h0a
`define MEM_MAX 4'hc
`endif

// ==== tooth_pkg.sv ====
// Types shared by the tooth switch logic
`include "tooth_cfg.svh"
package tooth_pkg;
   typedef logic [`SAMPLE_W-1:0] sample_t;
   typedef enum logic [1:0] {PT_THIRTY, PT_FIFTY, PT_CUSTOM} pointMode_t;
   typedef enum logic [1:0] {ST_HOLD, ST_VALLEY, ST_TOOTH} trackState_t;
endpackage

// ==== tooth_if.sv ====
// Carrier between the core, the peak memory and the switch-point calculator
`timescale 1ns/1ps
interface tooth_if;
   tooth_pkg::sample_t peakIn, peakOut, peakRef, valleyRef;
   tooth_pkg::sample_t opRise, relFall, dropAmt;
   logic peakWr, ptrClear;
   logic [3:0] memCount;
   tooth_pkg::pointMode_t pointMode;
   logic [5:0] opCode, relCode;
   logic [3:0] hystCode;
   modport core (output peakIn, peakWr, ptrClear, memCount, peakRef, valleyRef,
      pointMode, opCode, relCode, hystCode, input peakOut, opRise, relFall, dropAmt);
   modport mem_side (input peakIn, peakWr, ptrClear, memCount, output peakOut);
   modport calc_side (input peakRef, valleyRef, pointMode, opCode, relCode, hystCode,
      output opRise, relFall, dropAmt);
endinterface

// ==== peak_memory.sv ====
// Circular store of tooth peak values
`timescale 1ns/1ps
`include "tooth_cfg.svh"
module peak_memory #(parameter int MEM_DEPTH = 12) (
   // Clock, reset and clock enable
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   // Peak store and lookup
   tooth_if.mem_side io
);
   tooth_pkg::sample_t mem_r [MEM_DEPTH];
   tooth_pkg::sample_t last_r;
   logic [3:0] ptr_r;
   logic filled_r;
   logic atEnd;
   logic [3:0] ptrNxt;

   // Wrap at the programmed count; oldest entry sits at the pointer
   assign atEnd = (ptr_r == io.memCount - 4'h1);
   assign ptrNxt = atEnd ? 4'h0 : ptr_r + 4'h1;
   assign io.peakOut = filled_r ? mem_r[ptr_r] : last_r;

   // Write one peak per tooth
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < MEM_DEPTH; i++) mem_r[i] <= '0;
         last_r <= '0;
         ptr_r <= 4'h0;
         filled_r <= 1'b0;
      end else if (clkEn && io.ptrClear) begin
         ptr_r <= 4'h0;
         filled_r <= 1'b0;
      end else if (clkEn && io.peakWr) begin
         mem_r[ptr_r] <= io.peakIn;
         last_r <= io.peakIn;
         ptr_r <= ptrNxt;
         if (atEnd) filled_r <= 1'b1;
      end
   end

   property p_wrap;
      @(posedge ref_clk) disable iff (rst)
      clkEn && io.peakWr && !io.ptrClear |=> ptr_r == $past(ptrNxt);
   endproperty
   a_wrap: assert property (p_wrap) else $error("peak pointer wrong");
   property p_single;
      @(posedge ref_clk) disable iff (rst)
      clkEn && io.peakWr && !io.ptrClear && io.memCount == 4'h1
         |=> io.peakOut == $past(io.peakIn);
   endproperty
   a_single: assert property (p_single) else $error("n=1 not last peak");
   property p_aged;
      @(posedge ref_clk) disable iff (rst)
      clkEn && io.peakWr && !io.ptrClear && filled_r && io.memCount > 4'h1
         |=> io.peakOut == $past(mem_r[ptrNxt]);
   endproperty
   a_aged: assert property (p_aged) else $error("peak not n teeth old");
endmodule // peak_memory

// ==== switch_point_calc.sv ====
// Operate and release thresholds from tracked peak and valley
`timescale 1ns/1ps
`include "tooth_cfg.svh"
module switch_point_calc (
   // Clock and reset for checks
   input wire logic ref_clk,
   input wire logic rst,
   // Threshold inputs and results
   tooth_if.calc_side io
);
   logic [5:0] opEff, relEff, opClamp, relClamp;
   logic [3:0] hystEff;
   logic [11:0] span, opOfs, relOfs, hystHalf;
   logic [17:0] opProd, relProd, dropProd;
   logic [15:0] hystProd;
   logic [12:0] opSum, relPoint;

   // Point codes by mode, custom codes held to 30..50 percent
   assign opClamp = io.opCode < `CODE_THIRTY ? `CODE_THIRTY :
      io.opCode > `CODE_FIFTY ? `CODE_FIFTY : io.opCode;
   assign relClamp = io.relCode < `CODE_THIRTY ? `CODE_THIRTY :
      io.relCode > `CODE_FIFTY ? `CODE_FIFTY : io.relCode;
   assign opEff = io.pointMode == tooth_pkg::PT_THIRTY ? `CODE_THIRTY :
      io.pointMode == tooth_pkg::PT_FIFTY ? `CODE_FIFTY : opClamp;
   assign relEff = io.pointMode == tooth_pkg::PT_THIRTY ? `CODE_THIRTY :
      io.pointMode == tooth_pkg::PT_FIFTY ? `CODE_FIFTY : relClamp;
   assign hystEff = io.hystCode < `HYS_MIN ? `HYS_MIN :
      io.hystCode > `HYS_MAX ? `HYS_MAX : io.hystCode;

   // Span and scaled offsets above the valley
   assign span = io.peakRef > io.valleyRef ? io.peakRef - io.valleyRef : 12'h000;
   assign opProd = span * opEff;
   assign relProd = span * relEff;
   assign hystProd = span * hystEff;
   assign dropProd = span * (opEff - `DROP_MARGIN);
   assign opOfs = opProd[17:6];
   assign relOfs = relProd[17:6];
   assign hystHalf = {3'h0, hystProd[15:7]};
   assign io.dropAmt = dropProd[17:6];

   // Half the hysteresis on each side of the points
   assign opSum = {1'b0, io.valleyRef} + {1'b0, opOfs} + {1'b0, hystHalf};
   assign relPoint = {1'b0, io.valleyRef} + {1'b0, relOfs};
   assign io.opRise = opSum[12] ? 12'hfff : opSum[11:0];
   assign io.relFall = relPoint[11:0] > hystHalf ? relPoint[11:0] - hystHalf : 12'h000;

   property p_fixed;
      @(posedge ref_clk) disable iff (rst)
      io.pointMode == tooth_pkg::PT_FIFTY |-> opEff == `CODE_FIFTY && relEff == `CODE_FIFTY;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fifty percent code wrong");
   property p_custom;
      @(posedge ref_clk) disable iff (rst)
      opEff >= `CODE_THIRTY && opEff <= `CODE_FIFTY && hystEff >= `HYS_MIN
         && hystEff <= `HYS_MAX;
   endproperty
   a_custom: assert property (p_custom) else $error("point code out of range");
endmodule // switch_point_calc

// ==== ecu_model.sv ====
// Engine controller model that counts the edges of the switched output
`timescale 1ns/1ps
module ecu_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Switched output of the sensor
   input wire logic switchOut,
   // Edges seen so far
   output logic [15:0] edgeCount
);
   logic lastLevel_r;
   logic [15:0] edgeCnt_r;
   assign edgeCount = edgeCnt_r;
   // Count every level change, as the controller times teeth from edges
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lastLevel_r <= 1'b1;
         edgeCnt_r <= 16'h0;
      end else begin
         lastLevel_r <= switchOut;
         edgeCnt_r <= edgeCnt_r + {15'h0, switchOut !== lastLevel_r};
      end
   end
endmodule // ecu_model

// ==== tooth_threshold_switch_logic_tb.sv ====
// Testbench for registers and switching of the tooth switch logic
`timescale 1ns/1ps
`include "tooth_cfg.svh"
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin failCount++; \
   $display("wrong value at %0t: %h expected %h", $time, a, e); end end
module tooth_threshold_switch_logic_tb;
   // ----------------
   // Signals
   // ----------------
   logic ref_clk, rst, clkEn, read, write, waitrequest, sampleValid, switchOut;
   logic [5:0] address;
   logic [31:0] writedata, readdata, q;
   logic [3:0] byteenable;
   tooth_pkg::sample_t sample;
   logic [15:0] edgeCount, e0;
   int failCount, checksDone, cycles;
   // ----------------
   // Instances
   // ----------------
   tooth_threshold_switch_logic uut (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .sample(sample), .sampleValid(sampleValid), .switchOut(switchOut));
   ecu_model ecu (.ref_clk(ref_clk), .rst(rst), .switchOut(switchOut), .edgeCount(edgeCount));
   // Clock and hang guard
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failCount++;
         close_out();
      end
   end
   // ----------------
   // Tasks
   // ----------------
   task close_out;
      if (failCount == 0 && checksDone > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // One Avalon transfer, held until waitrequest is seen low
   task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      address <= a;
      writedata <= d;
      read <= ~wr;
      write <= wr;
      do @(posedge ref_clk);
      while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task rd(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask
   // One valley then one tooth; p is the level expected on the tooth
   task tooth(input logic [11:0] pk, input logic [11:0] vl, input logic p, input bit chk);
      @(posedge ref_clk);
      sample <= vl;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      if (chk) `CHK(switchOut, ~p)
      @(posedge ref_clk);
      sample <= pk;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      if (chk) `CHK(switchOut, p)
   endtask
   // ----------------
   // Main sequence
   // ----------------
   initial begin
      rst = 1'b1;
      clkEn = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 6'h00;
      writedata = 32'h0;
      byteenable = 4'hf;
      sample = 12'h000;
      sampleValid = 1'b1;
      failCount = 0;
      checksDone = 0;
      cycles = 0;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      rd(`OFS_CTRL, 32'h0);
      rd(`OFS_MEMCNT, 32'h1);
      rd(`OFS_POINTS, 32'h00061313);
      rd(`OFS_BOUND, 32'h040);
      rd(`OFS_STATUS, 32'h1);
      rd(6'h3c, 32'h0);
      bus(1'b1, `OFS_MEMCNT, 32'h0);
      rd(`OFS_MEMCNT, 32'h1);
      bus(1'b1, `OFS_MEMCNT, 32'hf);
      rd(`OFS_MEMCNT, 32'hc);
      bus(1'b1, `OFS_MEMCNT, 32'h1);
      // Low on tooth, thirty percent points; a peak is seen while held
      sample <= 12'h900;
      bus(1'b1, `OFS_CTRL, 32'h10);
      tooth(12'h900, 12'h080, 1'b0, 1'b0);
      e0 = edgeCount;
      repeat (2) tooth(12'h900, 12'h100, 1'b0, 1'b1);
      `CHK(edgeCount, e0 + 16'h4)
      rd(`OFS_PEAK, 32'h900);
      rd(`OFS_VALLEY, 32'h100);
      rd(`OFS_OPTH, 32'h3c0);
      rd(`OFS_RELTH, 32'h300);
      // High on tooth, fifty percent points
      bus(1'b1, `OFS_CTRL, 32'h15);
      repeat (2) tooth(12'h900, 12'h100, 1'b1, 1'b1);
      rd(`OFS_OPTH, 32'h560);
      rd(`OFS_RELTH, 32'h4a0);
      // Custom points set apart
      bus(1'b1, `OFS_CTRL, 32'h18);
      bus(1'b1, `OFS_POINTS, 32'h00041a20);
      rd(`OFS_POINTS, 32'h00041a20);
      tooth(12'h900, 12'h100, 1'b0, 1'b1);
      rd(`OFS_OPTH, 32'h540);
      rd(`OFS_RELTH, 32'h400);
      // Valley jump refused when bounded, taken when continuous
      bus(1'b1, `OFS_CTRL, 32'h1a);
      repeat (2) tooth(12'h900, 12'h200, 1'b0, 1'b1);
      rd(`OFS_VALLEY, 32'h100);
      bus(1'b1, `OFS_CTRL, 32'h18);
      repeat (2) tooth(12'h900, 12'h200, 1'b0, 1'b1);
      rd(`OFS_VALLEY, 32'h200);
      // Two deep memory with alternating peaks
      bus(1'b1, `OFS_MEMCNT, 32'h2);
      repeat (2) tooth(12'h900, 12'h200, 1'b0, 1'b0);
      tooth(12'ha00, 12'h200, 1'b0, 1'b0);
      tooth(12'h900, 12'h200, 1'b0, 1'b0);
      tooth(12'ha00, 12'h200, 1'b0, 1'b0);
      tooth(12'h900, 12'h200, 1'b0, 1'b0);
      rd(`OFS_PEAK, 32'h900);
      // Amplitude drop raises the flag, write one clears it
      bus(1'b1, `OFS_MEMCNT, 32'h1);
      tooth(12'h900, 12'h200, 1'b0, 1'b0);
      tooth(12'h600, 12'h200, 1'b0, 1'b0);
      tooth(12'h900, 12'h200, 1'b0, 1'b0);
      bus(1'b0, `OFS_STATUS, 32'h0);
      `CHK(q[2], 1'b1)
      bus(1'b1, `OFS_STATUS, 32'h4);
      bus(1'b0, `OFS_STATUS, 32'h0);
      `CHK(q[2], 1'b0)
      // Frozen clock enable, then invalid samples, hold the output
      clkEn <= 1'b0;
      sample <= 12'h200;
      repeat (4) @(posedge ref_clk);
      `CHK(switchOut, 1'b0)
      clkEn <= 1'b1;
      sampleValid <= 1'b0;
      repeat (4) @(posedge ref_clk);
      `CHK(switchOut, 1'b0)
      sampleValid <= 1'b1;
      repeat (4) @(posedge ref_clk);
      `CHK(switchOut, 1'b1)
      close_out();
   end
endmodule // tooth_threshold_switch_logic_tb
